// file: common/mbs_consts.svh
// Constants for the multiphase buck sequencer
`ifndef MBS_CONSTS_SVH
`define MBS_CONSTS_SVH
`define MBS_REF_MHZ_X100      15625
`define MBS_DIV_MIN           7'h06
`define MBS_DIV_MAX           7'h7F
`define MBS_PH_MIN            3'h2
`define MBS_PH_MAX            3'h6
`define MBS_IADC_BITS         6
`define MBS_IADC_STEP_NA      4300
`define MBS_NVM_WORDS         16
`define MBS_VCODE_OFF         6'h3F
`define MBS_RESTART_DLY       16'h0400
`define MBS_TEMP_EVERY        8'h40
`define MBS_SEG_COUNT         4
`define MBS_ADDR_DIV          4'h0
`define MBS_ADDR_PHASES       4'h1
`define MBS_ADDR_FLAGS        4'h2
`define MBS_ADDR_CAL_V        4'h3
`define MBS_ADDR_CAL_I        4'h4
`define MBS_ADDR_SS_STEP      4'h5
`define MBS_ADDR_SD_STEP      4'h6
`define MBS_ADDR_IDELAY       4'h7
`define MBS_ADDR_SETPT        4'h8
`define MBS_ADDR_FLTMASK      4'h9
`define MBS_ADDR_FLTLATCH     4'hA
`define MBS_ADDR_SEG_BASE     4'hB
`define MBS_ADDR_PTAT         4'hF
`define MBS_FLAG_UVLO         0
`define MBS_FLAG_CAL          1
`define MBS_FLAG_SPREAD       2
`define MBS_FLAG_NULL         3
`endif

// file: common/mbs_pkg.sv
// Types for the multiphase buck sequencer
package mbs_pkg;
  typedef enum logic [2:0] {
    MBS_CONFIG   = 3'b000,
    MBS_INACTIVE = 3'b001,
    MBS_SOFT     = 3'b010,
    MBS_CAL      = 3'b011,
    MBS_LEAK     = 3'b100,
    MBS_ACTIVE   = 3'b101,
    MBS_SHUTDOWN = 3'b110,
    MBS_HOLDOFF  = 3'b111
  } mbs_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } mbs_nvm_t;

  typedef struct packed {
    logic [7:0] target;
    logic [7:0] width;
    logic       stage_oe;
    logic       power_good;
  } mbs_drive_t;
endpackage

// file: design/mbs_sequencer.sv
// Operating sequencer, switching timebase and ADC sampling schedule
//
// Contract
// - Configure after power-on or external reset
// - Copy non-volatile memory into configuration registers
// - Outputs undriven while configuring
// - Then inactive: defaults out, faults reported
// - Soft-start needs valid code, enable, supply
// - Supply valid needs comparator when lockout enabled
// - Ramp target monotonically from zero to setpoint
// - Calibrate each phase at low voltage
// - Calibration skippable; current and voltage programmable
// - Measure leakage current before active regulation
// - Raise power good on entering active
// - Shutdown on disable, all-ones code, fault
// - Shrink width steadily, then undrive power stage
// - Fixed delay before returning to inactive
// - Latched fault blocks restart until intervention
// - Optional pseudo-random spread of timing reference
// - Switching frequency from divider and phase count
// - Two to six active phases
// - Voltage ADC strobes two per phase per cycle
// - Optional ripple null at ripple frequency
// - Shared six-bit current ADC, multiplexed phases
// - Current sample per phase, delayed mid on-time
// - Piecewise thermistor table, linear internal fit
// - Temperatures multiplexed through current ADC slowly
`include "mbs_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module mbs_sequencer
  import mbs_pkg::*;
#(
  parameter int RESTART_DLY = 1024
) (
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       por_n_in,
  input  wire logic       output_enable_in,
  input  wire logic [5:0] voltage_code_in,
  input  wire logic       supply_cmp_in,
  input  wire logic [1:0] fault_in,
  input  wire logic       nvm_valid_in,
  input  wire logic [7:0] nvm_data_in,
  input  wire logic [5:0] iadc_data_in,
  input  wire logic       vadc_ready_in,
  input  wire logic [7:0] vadc_data_in,
  input  wire logic [7:0] sd_target_in,
  input  wire logic [3:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic [7:0]      reg_rdata_out,
  output logic [3:0]      nvm_addr_out,
  output logic            nvm_rd_out,
  output logic            power_good_out,
  output logic            power_good_oe_out,
  output logic            stage_oe_out,
  output logic [7:0]      pulse_width_out,
  output logic [7:0]      target_out,
  output logic            cal_load_en_out,
  output logic [7:0]      cal_current_out,
  output logic [2:0]      cal_phase_out,
  output logic [2:0]      iadc_sel_out,
  output logic            iadc_strobe_out,
  output logic            vadc_strobe_out,
  output logic [7:0]      vadc_filt_out,
  output logic [7:0]      temp_ext_out,
  output logic [7:0]      temp_int_out,
  output logic [5:0]      leak_out,
  output logic [7:0]      gain_corr_out,
  output logic [7:0]      fault_status_out,
  output logic [2:0]      state_out
);

  // Rounds an in-range divider setting
  function automatic logic [6:0] clamp_div(input logic [7:0] v);
    if (v[6:0] < `MBS_DIV_MIN) return `MBS_DIV_MIN;
    return v[6:0];
  endfunction

  // Rounds an in-range phase count
  function automatic logic [2:0] clamp_ph(input logic [7:0] v);
    if (v[2:0] < `MBS_PH_MIN) return `MBS_PH_MIN;
    if (v[2:0] > `MBS_PH_MAX) return `MBS_PH_MAX;
    return v[2:0];
  endfunction

  // Pin synchronisers and reset sources
  logic [1:0] oe_s_q, sup_s_q, por_s_q;
  logic [1:0] flt_s1_q, flt_s2_q;
  logic [5:0] vc_s1_q, vc_s2_q, vc_s3_q;
  always_ff @(posedge core_clk_in) begin
    oe_s_q   <= {oe_s_q[0], output_enable_in};
    sup_s_q  <= {sup_s_q[0], supply_cmp_in};
    por_s_q  <= {por_s_q[0], por_n_in};
    flt_s1_q <= fault_in;
    flt_s2_q <= flt_s1_q;
    vc_s1_q  <= voltage_code_in;
    vc_s2_q  <= vc_s1_q;
    vc_s3_q  <= vc_s2_q;
  end
  logic oe_q;
  always_ff @(posedge core_clk_in) oe_q <= oe_s_q[1];
  wire logic rst_all = !rst_n_in || !por_s_q[1];

  // Configuration registers, filled from memory then writable
  logic [7:0] cfg_q [0:`MBS_NVM_WORDS-1];
  logic [4:0] load_idx_q;
  logic       loading_q;
  mbs_state_t st_q;
  always_ff @(posedge core_clk_in) begin
    if (rst_all) begin
      load_idx_q <= 5'h00;
      loading_q  <= 1'b0;
    end else if (st_q == MBS_CONFIG) begin
      loading_q <= 1'b1;
      if (loading_q && nvm_valid_in) begin
        cfg_q[load_idx_q[3:0]] <= nvm_data_in;
        load_idx_q <= load_idx_q + 5'h01;
      end
    end else if (reg_wr_in && reg_addr_in != `MBS_ADDR_PTAT) begin
      cfg_q[reg_addr_in] <= reg_wdata_in;
    end
  end
  wire logic cfg_done = load_idx_q == 5'(`MBS_NVM_WORDS);
  // Request follows the index as it stands after this edge, so a consumed word is never asked again
  wire logic       nvm_take = (st_q == MBS_CONFIG) && loading_q && nvm_valid_in;
  wire logic [4:0] load_nxt = load_idx_q + {4'h0, nvm_take};
  always_ff @(posedge core_clk_in) begin
    nvm_addr_out <= load_nxt[3:0];
    nvm_rd_out   <= (st_q == MBS_CONFIG) && load_nxt != 5'(`MBS_NVM_WORDS) && !rst_all;
  end

  wire logic [6:0] div_sel = clamp_div(cfg_q[`MBS_ADDR_DIV]);
  wire logic [2:0] nph = clamp_ph(cfg_q[`MBS_ADDR_PHASES]);
  wire logic [7:0] flags = cfg_q[`MBS_ADDR_FLAGS];
  wire logic [7:0] setpoint = cfg_q[`MBS_ADDR_SETPT];

  // Spread spectrum LFSR
  logic [7:0] lfsr_q;
  always_ff @(posedge core_clk_in) begin
    if (rst_all) lfsr_q <= 8'h01;
    else lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end
  wire logic [6:0] div_eff = (flags[`MBS_FLAG_SPREAD] && lfsr_q[0] && div_sel < `MBS_DIV_MAX) ?
                             div_sel + 7'h01 : div_sel;

  // Sample-rate divider: one voltage strobe per div_eff ticks
  logic [6:0] div_cnt_q;
  logic [3:0] half_q;   // half-cycle index, two per phase
  logic       samp_tick;
  assign samp_tick = div_cnt_q >= div_eff - 7'h01;
  always_ff @(posedge core_clk_in) begin
    if (rst_all) begin
      div_cnt_q <= 7'h00;
      half_q    <= 4'h0;
    end else if (samp_tick) begin
      div_cnt_q <= 7'h00;
      half_q    <= (half_q >= {nph, 1'b0} - 4'h1) ? 4'h0 : half_q + 4'h1;
    end else begin
      div_cnt_q <= div_cnt_q + 7'h01;
    end
  end
  wire logic cycle_start = samp_tick && half_q == 4'h0;
  wire logic [2:0] cur_phase = 3'(half_q >> 1);

  // Ripple null: average over one ripple period, two samples or 1/nph of a switching period
  logic [7:0] vprev_q;
  logic [8:0] vsum;
  assign vsum = {1'b0, vadc_data_in} + {1'b0, vprev_q};
  always_ff @(posedge core_clk_in) begin
    if (rst_all) begin
      vprev_q       <= 8'h00;
      vadc_filt_out <= 8'h00;
    end else if (vadc_ready_in) begin
      vprev_q       <= vadc_data_in;
      vadc_filt_out <= flags[`MBS_FLAG_NULL] ? vsum[8:1] : vadc_data_in;
    end
  end

  // Current ADC schedule: one delayed sample per phase, temperatures interleaved
  logic [7:0] idly_q, tdiv_q;
  logic       iarm_q, tturn_q;
  always_ff @(posedge core_clk_in) begin
    if (rst_all) begin
      idly_q <= 8'h00; iarm_q <= 1'b0; tdiv_q <= 8'h00; tturn_q <= 1'b0;
      iadc_sel_out <= 3'h0; iadc_strobe_out <= 1'b0; vadc_strobe_out <= 1'b0;
    end else begin
      vadc_strobe_out <= samp_tick;
      iadc_strobe_out <= 1'b0;
      if (samp_tick && !half_q[0]) begin
        iarm_q <= 1'b1;
        idly_q <= cfg_q[`MBS_ADDR_IDELAY];
      end else if (iarm_q) begin
        if (idly_q == 8'h00) begin
          iarm_q          <= 1'b0;
          iadc_strobe_out <= 1'b1;
          iadc_sel_out    <= cur_phase;
        end else idly_q <= idly_q - 8'h01;
      end
      if (cycle_start) begin
        tdiv_q <= tdiv_q + 8'h01;
        if (tdiv_q == `MBS_TEMP_EVERY) begin
          tdiv_q <= 8'h00;
          tturn_q <= !tturn_q;
          iadc_strobe_out <= 1'b1;
          iadc_sel_out    <= tturn_q ? 3'h7 : 3'h6;
        end
      end
    end
  end

  // Temperature conversion: 4-segment table and linear internal fit
  logic [7:0] seg_val;
  always_comb begin
    seg_val = 8'h00;
    unique case (iadc_data_in[5:4])
      2'h0: seg_val = cfg_q[`MBS_ADDR_SEG_BASE];
      2'h1: seg_val = cfg_q[`MBS_ADDR_SEG_BASE + 4'h1];
      2'h2: seg_val = cfg_q[`MBS_ADDR_SEG_BASE + 4'h2];
      2'h3: seg_val = cfg_q[`MBS_ADDR_SEG_BASE + 4'h3];
    endcase
  end
  logic iadc_strobe_d1_q;
  logic [2:0] sel_d1_q;
  always_ff @(posedge core_clk_in) begin
    iadc_strobe_d1_q <= iadc_strobe_out;
    sel_d1_q         <= iadc_sel_out;
    if (rst_all) begin
      temp_ext_out <= 8'h00;
      temp_int_out <= 8'h00;
    end else if (iadc_strobe_d1_q && sel_d1_q == 3'h7) begin
      temp_ext_out <= seg_val - {4'h0, iadc_data_in[3:0]};
    end else if (iadc_strobe_d1_q && sel_d1_q == 3'h6) begin
      temp_int_out <= 8'({iadc_data_in, 1'b0}) + cfg_q[`MBS_ADDR_PTAT];
    end
  end

  // Fault latching
  wire logic [1:0] flt_act = flt_s2_q & cfg_q[`MBS_ADDR_FLTMASK][1:0];
  wire logic       sup_ok  = !flags[`MBS_FLAG_UVLO] || sup_s_q[1];
  logic [1:0] latched_q;
  always_ff @(posedge core_clk_in) begin
    if (rst_all) latched_q <= 2'b00;
    else if (|(flt_act & cfg_q[`MBS_ADDR_FLTLATCH][1:0]))
      latched_q <= latched_q | (flt_act & cfg_q[`MBS_ADDR_FLTLATCH][1:0]);
    else if (oe_q && !oe_s_q[1]) latched_q <= 2'b00;
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_all) fault_status_out <= 8'h00;
    else fault_status_out <= {!sup_ok, 3'h0, latched_q, flt_s2_q};
  end

  // Operating sequence
  logic [15:0] wait_q;
  logic [2:0]  cal_ph_q;
  // The code crosses bit by bit, so act on it only after two equal samples
  wire logic vc_steady = vc_s2_q == vc_s3_q;
  wire logic run_ok = vc_steady && vc_s2_q != `MBS_VCODE_OFF && oe_s_q[1] && sup_ok;
  wire logic stop = !oe_s_q[1] || (vc_steady && vc_s2_q == `MBS_VCODE_OFF) || |flt_act;
  always_ff @(posedge core_clk_in) begin
    if (rst_all) begin
      st_q <= MBS_CONFIG; target_out <= 8'h00; pulse_width_out <= 8'h00;
      wait_q <= 16'h0000; cal_ph_q <= 3'h0; leak_out <= 6'h00; gain_corr_out <= 8'h80;
    end else begin
      unique case (st_q)
        MBS_CONFIG: if (cfg_done) st_q <= MBS_INACTIVE;
        MBS_INACTIVE: begin
          target_out <= 8'h00;
          if (run_ok && latched_q == 2'b00) st_q <= MBS_SOFT;
        end
        MBS_SOFT, MBS_CAL, MBS_LEAK, MBS_ACTIVE: begin
          pulse_width_out <= vadc_filt_out < target_out ? 8'hFF : 8'h00;
          if (stop) st_q <= MBS_SHUTDOWN;
          else if (st_q == MBS_SOFT && cycle_start) begin
            if (flags[`MBS_FLAG_CAL] && cal_ph_q < nph && target_out >= cfg_q[`MBS_ADDR_CAL_V])
              st_q <= MBS_CAL;
            else if (target_out < setpoint)
              target_out <= (setpoint - target_out > cfg_q[`MBS_ADDR_SS_STEP]) ?
                            target_out + cfg_q[`MBS_ADDR_SS_STEP] : setpoint;
            else st_q <= MBS_LEAK;
          end else if (st_q == MBS_CAL && iadc_strobe_d1_q && sel_d1_q == cal_ph_q) begin
            gain_corr_out <= {2'b00, iadc_data_in} + 8'h40;
            cal_ph_q <= cal_ph_q + 3'h1;
            st_q <= MBS_SOFT;
          end else if (st_q == MBS_LEAK && iadc_strobe_d1_q && sel_d1_q < 3'h6) begin
            leak_out <= iadc_data_in;
            st_q <= MBS_ACTIVE;
          end
        end
        MBS_SHUTDOWN: if (samp_tick) begin
          if (pulse_width_out > cfg_q[`MBS_ADDR_SD_STEP])
            pulse_width_out <= pulse_width_out - cfg_q[`MBS_ADDR_SD_STEP];
          else begin
            pulse_width_out <= 8'h00;
            st_q <= MBS_HOLDOFF;
            wait_q <= 16'(RESTART_DLY);
            cal_ph_q <= 3'h0;
          end
        end
        MBS_HOLDOFF: begin
          if (wait_q == 16'h0000) st_q <= MBS_INACTIVE;
          else wait_q <= wait_q - 16'h0001;
        end
      endcase
    end
  end
  wire logic unused_sd = ^sd_target_in;

  // Output drive
  always_ff @(posedge core_clk_in) begin
    if (rst_all) begin
      power_good_out <= 1'b0; power_good_oe_out <= 1'b0; stage_oe_out <= 1'b0;
      cal_load_en_out <= 1'b0; cal_current_out <= 8'h00; cal_phase_out <= 3'h0;
      reg_rdata_out <= 8'h00; state_out <= 3'h0;
    end else begin
      power_good_out    <= st_q == MBS_ACTIVE;
      power_good_oe_out <= st_q != MBS_CONFIG;
      stage_oe_out      <= st_q inside {MBS_SOFT, MBS_CAL, MBS_LEAK, MBS_ACTIVE} ||
                           (st_q == MBS_SHUTDOWN && pulse_width_out != 8'h00);
      cal_load_en_out   <= st_q == MBS_CAL;
      cal_current_out   <= st_q == MBS_CAL ? cfg_q[`MBS_ADDR_CAL_I] : 8'h00;
      cal_phase_out     <= cal_ph_q;
      state_out         <= st_q;
      reg_rdata_out     <= reg_rd_in ? (reg_addr_in == `MBS_ADDR_PTAT ? {5'h00, st_q} : cfg_q[reg_addr_in]) : 8'h00;
    end
  end
endmodule
`default_nettype wire

// file: bench/mbs_sequencer_chk.sv
// Port checker for the sequencer, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module mbs_sequencer_chk
  import mbs_pkg::*;
#(
  parameter int RESTART_DLY = 1024
) (
  input wire logic       core_clk_in,
  input wire logic       rst_n_in,
  input wire logic       por_n_in,
  input wire logic       nvm_rd_out,
  input wire logic       power_good_out,
  input wire logic       power_good_oe_out,
  input wire logic       stage_oe_out,
  input wire logic [7:0] pulse_width_out,
  input wire logic [7:0] target_out,
  input wire logic [2:0] state_out
);
  logic [15:0] hold_q;
  // Counts cycles spent in the restart delay
  always_ff @(posedge core_clk_in) begin
    if (state_out == MBS_HOLDOFF) begin
      hold_q <= hold_q + 16'h0001;
    end else begin
      hold_q <= 16'h0000;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in || !por_n_in);
  AST_CFG_HIZ: assert property (state_out == MBS_CONFIG |-> !stage_oe_out && !power_good_oe_out)
    else $error("output driven while configuring");
  AST_NVM_CFG: assert property (nvm_rd_out |-> state_out == MBS_CONFIG)
    else $error("memory read outside configuration");
  AST_LEAVE_IDLE: assert property ($past(state_out) == MBS_INACTIVE && state_out != MBS_INACTIVE
    |-> state_out inside {MBS_SOFT, MBS_CONFIG})
    else $error("inactive left for a wrong state");
  AST_INTO_SD: assert property (state_out == MBS_SHUTDOWN && $past(state_out) != MBS_SHUTDOWN
    |-> $past(state_out) inside {MBS_SOFT, MBS_CAL, MBS_LEAK, MBS_ACTIVE})
    else $error("shutdown entered from a wrong state");
  AST_RAMP_UP: assert property (state_out == MBS_SOFT && $past(state_out) == MBS_SOFT
    |-> target_out >= $past(target_out))
    else $error("target fell during soft-start");
  AST_SD_DOWN: assert property (state_out == MBS_SHUTDOWN && $past(state_out) == MBS_SHUTDOWN
    |-> pulse_width_out <= $past(pulse_width_out))
    else $error("width grew during shutdown");
  AST_SD_HIZ: assert property (state_out == MBS_HOLDOFF |-> !stage_oe_out && pulse_width_out == 8'h00)
    else $error("stage driven after shutdown");
  AST_PG_RISE: assert property ($rose(power_good_out) |-> state_out == MBS_ACTIVE && $past(state_out) == MBS_LEAK)
    else $error("power good rose outside active");
  AST_HOLD_LEN: assert property ($past(state_out) == MBS_HOLDOFF && state_out != MBS_HOLDOFF
    |-> state_out == MBS_INACTIVE && $past(hold_q) + 16'h0002 >= 16'(RESTART_DLY)
    && $past(hold_q) <= 16'(RESTART_DLY))
    else $error("restart delay length wrong");
endmodule
bind mbs_sequencer mbs_sequencer_chk #(.RESTART_DLY(RESTART_DLY)) u_chk (
  .core_clk_in, .rst_n_in, .por_n_in, .nvm_rd_out, .power_good_out, .power_good_oe_out,
  .stage_oe_out, .pulse_width_out, .target_out, .state_out);
`default_nettype wire

// file: bench/mbs_far_side.sv
// Far-side model: memory, current converter and voltage converter
`timescale 1ns/10ps
`default_nettype none
module mbs_far_side (
  input  wire logic       core_clk_in,
  input  wire logic [7:0] img_in [16],
  input  wire logic [5:0] ilvl_in,
  input  wire logic [3:0] nvm_addr_in,
  input  wire logic       nvm_rd_in,
  input  wire logic       iadc_strobe_in,
  input  wire logic [2:0] iadc_sel_in,
  input  wire logic       vadc_strobe_in,
  input  wire logic [7:0] target_in,
  output logic            nvm_valid_out,
  output logic [7:0]      nvm_data_out,
  output logic [5:0]      iadc_data_out,
  output logic            vadc_ready_out,
  output logic [7:0]      vadc_data_out
);
  // Memory answers after a random wait, shows inverted data when idle
  always @(posedge core_clk_in) begin
    nvm_valid_out <= nvm_rd_in && !nvm_valid_out && ($urandom_range(1, 0) == 1);
    nvm_data_out <= (nvm_rd_in && !nvm_valid_out) ? img_in[nvm_addr_in] : ~img_in[nvm_addr_in];
  end
  // Phases read the same level, temperature channels another
  always @(posedge core_clk_in) begin
    if (iadc_strobe_in) begin
      iadc_data_out <= (iadc_sel_in < 3'h6) ? ilvl_in : ~ilvl_in;
    end else begin
      iadc_data_out <= ~iadc_data_out;
    end
  end
  // Load voltage follows the target, one sample per strobe
  always @(posedge core_clk_in) begin
    vadc_ready_out <= vadc_strobe_in;
    vadc_data_out <= vadc_strobe_in ? target_in : ~target_in;
  end
endmodule
`default_nettype wire

// file: bench/mbs_sequencer_tb_top.sv
// Self-checking bench for the sequencer
`timescale 1ns/10ps
`default_nettype none
module mbs_sequencer_tb_top
  import mbs_pkg::*;
;
  localparam int HOLD = 16;
  localparam logic [7:0] IMG [16] = '{8'h06, 8'h02, 8'h0F, 8'h20, 8'h10, 8'h40, 8'h20, 8'h02,
                                      8'h90, 8'h03, 8'h01, 8'h10, 8'h20, 8'h30, 8'h40, 8'h00};
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       por_n = 1'b0;
  logic       en = 1'b0;
  logic [5:0] vcode = 6'h3F;
  logic       sup = 1'b0;
  logic [1:0] flt = 2'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       rd_p = 1'b0;
  logic [5:0] ilvl = 6'h15;
  logic       nvld, vrdy, nrd, pg, istb, vstb;
  logic [7:0] ndat, vdat, rdata, tgt;
  logic [5:0] idat, leak;
  logic [3:0] naddr;
  logic [2:0] isel, st;
  logic [7:0] expq [$];
  int         err_total = 0;
  int         n_compared = 0;

  mbs_sequencer #(.RESTART_DLY(HOLD)) u_dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .por_n_in(por_n), .output_enable_in(en),
    .voltage_code_in(vcode), .supply_cmp_in(sup), .fault_in(flt), .nvm_valid_in(nvld),
    .nvm_data_in(ndat), .iadc_data_in(idat), .vadc_ready_in(vrdy), .vadc_data_in(vdat),
    .sd_target_in(8'h00), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .nvm_addr_out(naddr), .nvm_rd_out(nrd),
    .power_good_out(pg), .power_good_oe_out(), .stage_oe_out(), .pulse_width_out(),
    .target_out(tgt), .cal_load_en_out(), .cal_current_out(), .cal_phase_out(),
    .iadc_sel_out(isel), .iadc_strobe_out(istb), .vadc_strobe_out(vstb), .vadc_filt_out(),
    .temp_ext_out(), .temp_int_out(), .leak_out(leak), .gain_corr_out(),
    .fault_status_out(), .state_out(st));

  mbs_far_side u_far (
    .core_clk_in(clk), .img_in(IMG), .ilvl_in(ilvl), .nvm_addr_in(naddr), .nvm_rd_in(nrd),
    .iadc_strobe_in(istb), .iadc_sel_in(isel), .vadc_strobe_in(vstb), .target_in(tgt),
    .nvm_valid_out(nvld), .nvm_data_out(ndat), .iadc_data_out(idat), .vadc_ready_out(vrdy),
    .vadc_data_out(vdat));

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic fail(input string m);
    err_total++;
    $display("mismatch t=%0t %s", $time, m);
  endtask

  task automatic summarize;
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Notes the expected data; the monitor compares it
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    expq.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic cmp_rd(input logic [7:0] got);
    logic [7:0] e;
    e = expq.pop_front();
    n_compared++;
    if (got !== e) fail("read data");
  endtask

  task automatic cmp_val(input logic [7:0] got, input logic [7:0] e);
    n_compared++;
    if (got !== e) fail("output value");
  endtask

  task automatic wait_st(input mbs_state_t s, input int lim);
    int i;
    i = 0;
    while (st !== s && i < lim) begin
      @(posedge clk);
      i++;
    end
    n_compared++;
    if (st !== s) begin
      fail("state not reached");
      summarize();
    end
  endtask

  task automatic hold_st(input mbs_state_t s, input int n);
    repeat (n) begin
      @(posedge clk);
      n_compared++;
      if (st !== s) fail("state left");
    end
  endtask

  // Read data stand in the cycle after the strobe
  always @(posedge clk) begin
    rd_p <= rd;
    if (rd_p) cmp_rd(rdata);
  end

  // Main sequence
  initial begin
    logic [7:0] d;
    void'($urandom(32'h344e));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    wait_st(MBS_INACTIVE, 400);
    rd_reg(4'h8, IMG[8]);
    d = 8'($urandom_range(20, 6));
    wr_reg(4'h0, d);
    rd_reg(4'h0, d);
    wr_reg(4'hF, 8'h55);
    rd_reg(4'hF, 8'h01);
    en <= 1'b1;
    vcode <= 6'($urandom_range(62, 0));
    hold_st(MBS_INACTIVE, 30);
    sup <= 1'b1;
    wait_st(MBS_SOFT, 20);
    wait_st(MBS_ACTIVE, 20000);
    repeat (2) @(posedge clk);
    cmp_val({7'h00, pg}, 8'h01);
    cmp_val({2'h0, leak}, {2'h0, ilvl});
    cmp_val(tgt, IMG[8]);
    vcode <= 6'h3F;
    wait_st(MBS_SHUTDOWN, 20);
    wait_st(MBS_HOLDOFF, 20000);
    wait_st(MBS_INACTIVE, HOLD + 8);
    hold_st(MBS_INACTIVE, 30);
    vcode <= 6'h15;
    wait_st(MBS_SOFT, 20);
    en <= 1'b0;
    wait_st(MBS_SHUTDOWN, 20);
    wait_st(MBS_INACTIVE, 20000);
    en <= 1'b1;
    wait_st(MBS_ACTIVE, 20000);
    flt <= 2'h1;
    wait_st(MBS_SHUTDOWN, 20);
    flt <= 2'h0;
    wait_st(MBS_INACTIVE, 20000);
    hold_st(MBS_INACTIVE, 40);
    en <= 1'b0;
    repeat (4) @(posedge clk);
    en <= 1'b1;
    wait_st(MBS_SOFT, 20);
    por_n <= 1'b0;
    wait_st(MBS_CONFIG, 10);
    por_n <= 1'b1;
    wait_st(MBS_INACTIVE, 400);
    summarize();
  end
endmodule
`default_nettype wire
